// file: core/scb_pkg.sv
// constants, field layouts and carrier types of the second synthesizer config bank
// Operation
// - 0x10 bits 2:0 hold divisor bits 10:8
// - 0x11 holds divisor low byte, reset 0x3C
// - 0x12 holds fractional divisor bits 7:0
// - 0x13 holds fractional divisor bits 15:8
// - 0x14 holds spread step size low byte
// - 0x15 holds spread step size high byte
// - 0x16 holds spread step delta byte
// - 0x17 holds spread period bits 7:0
// - 0x18 bits 7:6 hold period bits 9:8
// - 0x18 bit 5 enables spread spectrum
// - 0x18 bits 4:1 add filter resistor segments
// - 0x18 bit 0 applies only 6k resistor
package scb_pkg;

   localparam int SCB_NUM_REGS = 9;
   localparam int SCB_ADDR_W = 8;

   // byte offsets of the bank
   localparam logic [7:0] SCB_OFS_INT_HIGH = 8'h10;
   localparam logic [7:0] SCB_OFS_INT_LOW = 8'h11;
   localparam logic [7:0] SCB_OFS_FRAC_LOW = 8'h12;
   localparam logic [7:0] SCB_OFS_FRAC_HIGH = 8'h13;
   localparam logic [7:0] SCB_OFS_STEP_LOW = 8'h14;
   localparam logic [7:0] SCB_OFS_STEP_HIGH = 8'h15;
   localparam logic [7:0] SCB_OFS_STEP_DELTA = 8'h16;
   localparam logic [7:0] SCB_OFS_PERIOD_LOW = 8'h17;
   localparam logic [7:0] SCB_OFS_CONTROL = 8'h18;

   // reset values, index 0 is offset 0x10
   localparam logic [SCB_NUM_REGS-1:0][7:0] SCB_RESET = {
      8'h0E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3C, 8'h00
   };

   // writable bits; the rest are reserved and read as zero
   localparam logic [SCB_NUM_REGS-1:0][7:0] SCB_WMASK = {
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07
   };

   // field positions inside the control byte
   localparam int SCB_CTL_PERIOD_HI = 6;
   localparam int SCB_CTL_SPREAD_EN = 5;
   localparam int SCB_CTL_R100K = 4;
   localparam int SCB_CTL_R50K = 3;
   localparam int SCB_CTL_R25K = 2;
   localparam int SCB_CTL_R12K5 = 1;
   localparam int SCB_CTL_ONLY_6K = 0;

   // byte-wide access from the serial host engine
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [SCB_ADDR_W-1:0] addr;
      logic [7:0] wr_data;
   } scb_req_t;

   // fields as seen by the synthesizer
   typedef struct packed {
      logic [10:0] int_divisor;
      logic [15:0] frac_divisor;
      logic [15:0] spread_step_size;
      logic [7:0] spread_step_delta;
      logic [9:0] spread_period;
      logic spread_enable;
      logic filter_res_seg_100k;
      logic filter_res_seg_50k;
      logic filter_res_seg_25k;
      logic filter_res_seg_12k5;
      logic filter_res_only_6k;
   } scb_cfg_t;

endpackage

// file: core/scb_regs.sv
// second synthesizer configuration byte registers and their read port
`timescale 1ns/1ps
`default_nettype none

// one configuration byte: reserved bits never load and read as zero
module scb_byte_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK = 8'hFF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [7:0] data,
   output logic [7:0] value
);

   // masking the reset too keeps reserved bits zero whatever the table says
   always_ff @(posedge clk) begin
      if (reset) begin
         value <= RESET_VALUE & WRITE_MASK;
      end else if (load) begin
         value <= data & WRITE_MASK;
      end
   end

endmodule

// register map of the bank, offset then bits, field and reset value
//   0x10 [7:3] reserved: writes ignored, read as zero
//   0x10 [2:0] integer divisor bits 10:8, reset 0
//   0x11 [7:0] integer divisor bits 7:0, reset 0x3C
//   0x12 [7:0] fractional divisor bits 7:0, reset 0
//   0x13 [7:0] fractional divisor bits 15:8, reset 0
//   0x14 [7:0] spread step size bits 7:0, reset 0
//   0x15 [7:0] spread step size bits 15:8, reset 0
//   0x16 [7:0] spread step delta, reset 0
//   0x17 [7:0] spread period bits 7:0, reset 0
//   0x18 [7:6] spread period bits 9:8, reset 0
//   0x18 [5] spread enable, reset 0
//   0x18 [4] 100k filter segment, reset 0
//   0x18 [3] 50k filter segment, reset 1
//   0x18 [2] 25k filter segment, reset 1
//   0x18 [1] 12.5k filter segment, reset 1
//   0x18 [0] 6k alone, reset 0
// multi-byte fields change byte by byte: the host must tolerate a half-written value
module scb_regs #(
   parameter int ADDR_W = scb_pkg::SCB_ADDR_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire scb_pkg::scb_req_t req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic access_miss,
   output logic cfg_updated,
   output scb_pkg::scb_cfg_t cfg
);

   // the bank occupies consecutive offsets from the integer divisor high byte
   localparam logic [7:0] BASE = scb_pkg::SCB_OFS_INT_HIGH;
   localparam logic [7:0] NEXT = 8'h01;
   localparam int NREG = scb_pkg::SCB_NUM_REGS;
   localparam int BYTE_W = 8;
   // width of the divisor bits kept in 0x10 and of the period bits kept in 0x18
   localparam int INT_HI_W = 3;
   localparam int PERIOD_HI_W = 2;

   // bank indices of the offsets
   localparam int IH = int'(scb_pkg::SCB_OFS_INT_HIGH - BASE);
   localparam int IL = int'(scb_pkg::SCB_OFS_INT_LOW - BASE);
   localparam int FL = int'(scb_pkg::SCB_OFS_FRAC_LOW - BASE);
   localparam int FH = int'(scb_pkg::SCB_OFS_FRAC_HIGH - BASE);
   localparam int SL = int'(scb_pkg::SCB_OFS_STEP_LOW - BASE);
   localparam int SH = int'(scb_pkg::SCB_OFS_STEP_HIGH - BASE);
   localparam int SD = int'(scb_pkg::SCB_OFS_STEP_DELTA - BASE);
   localparam int PL = int'(scb_pkg::SCB_OFS_PERIOD_LOW - BASE);
   localparam int CT = int'(scb_pkg::SCB_OFS_CONTROL - BASE);

   // the offsets of the bank need an eight-bit address
   if (ADDR_W != scb_pkg::SCB_ADDR_W) begin : g_bad_addr_w
      $error("scb_regs: ADDR_W must equal the bank address width");
   end

   // the bank is indexed by offset, so a gap in the map would misplace a field
   if (scb_pkg::SCB_OFS_INT_LOW != scb_pkg::SCB_OFS_INT_HIGH + NEXT) begin : g_gap_il
      $error("scb_regs: integer divisor low byte is not next to the high byte");
   end
   if (scb_pkg::SCB_OFS_FRAC_LOW != scb_pkg::SCB_OFS_INT_LOW + NEXT) begin : g_gap_fl
      $error("scb_regs: fractional low byte is out of place");
   end
   if (scb_pkg::SCB_OFS_FRAC_HIGH != scb_pkg::SCB_OFS_FRAC_LOW + NEXT) begin : g_gap_fh
      $error("scb_regs: fractional high byte is out of place");
   end
   if (scb_pkg::SCB_OFS_STEP_LOW != scb_pkg::SCB_OFS_FRAC_HIGH + NEXT) begin : g_gap_sl
      $error("scb_regs: step low byte is out of place");
   end
   if (scb_pkg::SCB_OFS_STEP_HIGH != scb_pkg::SCB_OFS_STEP_LOW + NEXT) begin : g_gap_sh
      $error("scb_regs: step high byte is out of place");
   end
   if (scb_pkg::SCB_OFS_STEP_DELTA != scb_pkg::SCB_OFS_STEP_HIGH + NEXT) begin : g_gap_sd
      $error("scb_regs: step delta byte is out of place");
   end
   if (scb_pkg::SCB_OFS_PERIOD_LOW != scb_pkg::SCB_OFS_STEP_DELTA + NEXT) begin : g_gap_pl
      $error("scb_regs: period low byte is out of place");
   end
   if (scb_pkg::SCB_OFS_CONTROL != scb_pkg::SCB_OFS_PERIOD_LOW + NEXT) begin : g_gap_ct
      $error("scb_regs: control byte is out of place");
   end
   if (CT != NREG - 1) begin : g_bad_count
      $error("scb_regs: register count does not match the map");
   end

   // a reset bit outside the write mask would be dropped without notice
   for (genvar k = 0; k < NREG; k++) begin : g_chk_reset
      if ((scb_pkg::SCB_RESET[k] & ~scb_pkg::SCB_WMASK[k]) != 8'h00) begin : g_bad_reset
         $error("scb_regs: reset value sets a reserved bit");
      end
   end

   // the period pair must lie inside the control byte
   if (scb_pkg::SCB_CTL_PERIOD_HI + PERIOD_HI_W > BYTE_W) begin : g_bad_period_pos
      $error("scb_regs: period high bits do not fit the control byte");
   end

   // single-bit controls must lie inside the control byte
   if (scb_pkg::SCB_CTL_SPREAD_EN >= BYTE_W || scb_pkg::SCB_CTL_R100K >= BYTE_W
         || scb_pkg::SCB_CTL_R50K >= BYTE_W || scb_pkg::SCB_CTL_R25K >= BYTE_W
         || scb_pkg::SCB_CTL_R12K5 >= BYTE_W || scb_pkg::SCB_CTL_ONLY_6K >= BYTE_W)
         begin : g_bad_ctl_pos
      $error("scb_regs: a control bit lies outside the control byte");
   end

   // per-offset storage, select, strobe and read terms
   wire logic [NREG-1:0][7:0] bank;
   wire logic [NREG-1:0] hit;
   wire logic [NREG-1:0] load;
   wire logic [NREG-1:0][7:0] rd_term;
   wire logic [NREG:0][7:0] rd_chain;

   // request decode as named wires so each pulse has one obvious source
   wire logic any_hit = |hit;
   wire logic any_req = req.rd_en | req.wr_en;
   wire logic wr_hit = req.wr_en & any_hit;
   wire logic miss = any_req & ~any_hit;

   // one select per offset; at most one is ever high
   for (genvar i = 0; i < NREG; i++) begin : g_hit
      assign hit[i] = req.addr == (BASE + 8'(i));
   end
   assign load = {NREG{req.wr_en}} & hit;

   // 0x10: divisor bits 10:8; the bits above are reserved
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[IH]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[IH])
   ) u_int_high (
      .clk(clk),
      .reset(reset),
      .load(load[IH]),
      .data(req.wr_data),
      .value(bank[IH])
   );

   // 0x11: divisor low byte
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[IL]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[IL])
   ) u_int_low (
      .clk(clk),
      .reset(reset),
      .load(load[IL]),
      .data(req.wr_data),
      .value(bank[IL])
   );

   // 0x12: fractional divisor low byte
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[FL]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[FL])
   ) u_frac_low (
      .clk(clk),
      .reset(reset),
      .load(load[FL]),
      .data(req.wr_data),
      .value(bank[FL])
   );

   // 0x13: fractional divisor high byte
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[FH]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[FH])
   ) u_frac_high (
      .clk(clk),
      .reset(reset),
      .load(load[FH]),
      .data(req.wr_data),
      .value(bank[FH])
   );

   // 0x14: spread step size low byte
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[SL]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[SL])
   ) u_step_low (
      .clk(clk),
      .reset(reset),
      .load(load[SL]),
      .data(req.wr_data),
      .value(bank[SL])
   );

   // 0x15: spread step size high byte
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[SH]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[SH])
   ) u_step_high (
      .clk(clk),
      .reset(reset),
      .load(load[SH]),
      .data(req.wr_data),
      .value(bank[SH])
   );

   // 0x16: spread step delta
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[SD]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[SD])
   ) u_step_delta (
      .clk(clk),
      .reset(reset),
      .load(load[SD]),
      .data(req.wr_data),
      .value(bank[SD])
   );

   // 0x17: spread period low byte
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[PL]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[PL])
   ) u_period_low (
      .clk(clk),
      .reset(reset),
      .load(load[PL]),
      .data(req.wr_data),
      .value(bank[PL])
   );

   // 0x18: period high pair, spread enable and filter segments
   scb_byte_reg #(
      .RESET_VALUE(scb_pkg::SCB_RESET[CT]),
      .WRITE_MASK(scb_pkg::SCB_WMASK[CT])
   ) u_control (
      .clk(clk),
      .reset(reset),
      .load(load[CT]),
      .data(req.wr_data),
      .value(bank[CT])
   );

   // read selection as an and-or chain; an unmapped address returns zero
   assign rd_chain[0] = 8'h00;
   for (genvar j = 0; j < NREG; j++) begin : g_rd_sel
      assign rd_term[j] = hit[j] ? bank[j] : 8'h00;
      assign rd_chain[j+1] = rd_chain[j] | rd_term[j];
   end
   wire logic [7:0] next_rd_data = rd_chain[NREG];

   // read data is held until the next read; a same-cycle write shows on the next read
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data <= 8'h00;
      end else if (req.rd_en) begin
         rd_data <= next_rd_data;
      end
   end

   // one-cycle answer strobe for every read, mapped or not
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.rd_en;
      end
   end

   // one-cycle pulse for any access outside the bank
   always_ff @(posedge clk) begin
      if (reset) begin
         access_miss <= 1'b0;
      end else begin
         access_miss <= miss;
      end
   end

   // one-cycle pulse when a mapped byte was written
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_updated <= 1'b0;
      end else begin
         cfg_updated <= wr_hit;
      end
   end

   // bytes of the bank by name
   wire logic [7:0] byte_int_high = bank[IH];
   wire logic [7:0] byte_int_low = bank[IL];
   wire logic [7:0] byte_frac_low = bank[FL];
   wire logic [7:0] byte_frac_high = bank[FH];
   wire logic [7:0] byte_step_low = bank[SL];
   wire logic [7:0] byte_step_high = bank[SH];
   wire logic [7:0] byte_step_delta = bank[SD];
   wire logic [7:0] byte_period_low = bank[PL];
   wire logic [7:0] byte_control = bank[CT];

   // integer divisor: high bits from 0x10, low byte from 0x11
   wire logic [10:0] field_int_divisor = {byte_int_high[INT_HI_W-1:0], byte_int_low};
   // fractional divisor and spread step, high byte first
   wire logic [15:0] field_frac_divisor = {byte_frac_high, byte_frac_low};
   wire logic [15:0] field_step_size = {byte_step_high, byte_step_low};
   wire logic [7:0] field_step_delta = byte_step_delta;

   // spread period: two high bits ride in the control byte
   wire logic [9:0] field_period = {byte_control[scb_pkg::SCB_CTL_PERIOD_HI +: PERIOD_HI_W],
      byte_period_low};
   wire logic field_spread_en = byte_control[scb_pkg::SCB_CTL_SPREAD_EN];

   // segments set add resistance, clear bypass it
   wire logic field_seg_100k = byte_control[scb_pkg::SCB_CTL_R100K];
   wire logic field_seg_50k = byte_control[scb_pkg::SCB_CTL_R50K];
   wire logic field_seg_25k = byte_control[scb_pkg::SCB_CTL_R25K];
   wire logic field_seg_12k5 = byte_control[scb_pkg::SCB_CTL_R12K5];
   // the analog side lets this override the other segments
   wire logic field_only_6k = byte_control[scb_pkg::SCB_CTL_ONLY_6K];

   // the struct is driven in one place so every field has a single source
   assign cfg = '{
      int_divisor: field_int_divisor,
      frac_divisor: field_frac_divisor,
      spread_step_size: field_step_size,
      spread_step_delta: field_step_delta,
      spread_period: field_period,
      spread_enable: field_spread_en,
      filter_res_seg_100k: field_seg_100k,
      filter_res_seg_50k: field_seg_50k,
      filter_res_seg_25k: field_seg_25k,
      filter_res_seg_12k5: field_seg_12k5,
      filter_res_only_6k: field_only_6k
   };

endmodule

`default_nettype wire

// file: dv/scb_regs_chk.sv
// assertions on the config bank ports
`timescale 1ns/1ps
`default_nettype none
module scb_regs_chk #(parameter int ADDR_W = 8) (
   input wire logic clk,
   input wire logic reset,
   input wire scb_pkg::scb_req_t req,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic access_miss,
   input wire logic cfg_updated,
   input wire scb_pkg::scb_cfg_t cfg
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // a write lands on its field one cycle on; 0x10 keeps only bits 2:0
   property p_wr(a, v);
      req.wr_en && req.addr == a |=> v == ($past(req.wr_data) & (a == 8'h10 ? 8'h07 : 8'hFF));
   endproperty
   a_int_hi: assert property (p_wr(8'h10, {5'h00, cfg.int_divisor[10:8]}))
      else $error("int high");
   a_int_lo: assert property (p_wr(8'h11, cfg.int_divisor[7:0])) else $error("int low");
   a_frac_lo: assert property (p_wr(8'h12, cfg.frac_divisor[7:0])) else $error("frac");
   a_step_hi: assert property (p_wr(8'h15, cfg.spread_step_size[15:8])) else $error("step");
   a_delta: assert property (p_wr(8'h16, cfg.spread_step_delta)) else $error("delta");
   a_period_lo: assert property (p_wr(8'h17, cfg.spread_period[7:0])) else $error("period");
   a_ctrl_load: assert property (p_wr(8'h18, {cfg.spread_period[9:8], cfg.spread_enable,
      cfg.filter_res_seg_100k, cfg.filter_res_seg_50k, cfg.filter_res_seg_25k,
      cfg.filter_res_seg_12k5, cfg.filter_res_only_6k})) else $error("control");
   a_rsv_zero: assert property (req.rd_en && req.addr == 8'h10 |=> rd_valid && !rd_data[7:3])
      else $error("reserved bits");
   a_frac_hi: assert property (p_wr(8'h13, cfg.frac_divisor[15:8])) else $error("frac high");
   a_step_lo: assert property (p_wr(8'h14, cfg.spread_step_size[7:0])) else $error("step low");
   a_rd_strobe: assert property (req.rd_en |=> rd_valid) else $error("read strobe");
   a_rd_quiet: assert property (!req.rd_en |=> !rd_valid) else $error("read quiet");
   a_upd_pulse: assert property (req.wr_en && req.addr inside {[8'h10:8'h18]} |=> cfg_updated)
      else $error("update pulse");
   a_upd_quiet: assert property (!req.wr_en |=> !cfg_updated) else $error("update quiet");
   a_miss_pulse: assert property ((req.rd_en || req.wr_en) && !(req.addr inside {[8'h10:8'h18]})
      |=> access_miss) else $error("miss pulse");
   a_miss_quiet: assert property (!req.rd_en && !req.wr_en |=> !access_miss)
      else $error("miss quiet");
   c_rw_same: cover property (req.wr_en && req.rd_en && req.addr == 8'h11);
   c_ctrl_wr: cover property (req.wr_en && req.addr == 8'h18);
   c_miss_rd: cover property (req.rd_en ##1 access_miss);
   c_update: cover property (cfg_updated);
endmodule
bind scb_regs scb_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .reset(reset), .req(req),
   .rd_data(rd_data), .rd_valid(rd_valid), .access_miss(access_miss),
   .cfg_updated(cfg_updated), .cfg(cfg));
`default_nettype wire

// file: dv/scb_host_model.sv
// host model issuing byte requests
`timescale 1ns/1ps
`default_nettype none
module scb_host_model (
   input wire logic clk,
   output var scb_pkg::scb_req_t req
);
   initial req = '{1'b0, 1'b0, 8'hFF, 8'h00};
   // launched after the edge so the bank samples a settled request
   task automatic acc(input logic w, r, input logic [7:0] a, d);
      @(posedge clk);
      req <= '{w, r, a, d};
   endtask
endmodule
`default_nettype wire

// file: dv/scb_regs_tb_top.sv
// self-checking bench for the config bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module scb_regs_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   scb_pkg::scb_req_t req;
   logic [7:0] rd_data;
   logic rd_valid, access_miss, cfg_updated;
   scb_pkg::scb_cfg_t cfg;
   int n_errors = 0;
   int n_checks = 0;
   int seed = 89;
   logic [8:0] q[$];
   logic [7:0] rv[9] = '{1:8'h3C, 8:8'h0E, default:8'h00};
   logic [7:0] sh[9];
   always #2 clk = ~clk;
   scb_regs #(.ADDR_W(8)) dut (.clk(clk), .reset(reset), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .access_miss(access_miss), .cfg_updated(cfg_updated), .cfg(cfg));
   scb_host_model host (.clk(clk), .req(req));
   // each read answer takes the oldest note
   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         if (q.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK({access_miss, rd_data}, q.pop_front())
      end
   end
   // note the read before the write lands: a same-cycle read returns the old byte
   task automatic op(input logic w, r, input logic [7:0] a, d);
      logic m;
      m = a >= 8'h10 && a <= 8'h18;
      host.acc(w, r, a, d);
      if (r) q.push_back(m ? {1'b0, sh[a - 8'h10]} : 9'h100);
      if (w && m) sh[a - 8'h10] = (a == 8'h10) ? d & 8'h07 : d;
   endtask
   task automatic drain();
      int i;
      op(1'b0, 1'b0, 8'hA5, 8'h5A);
      for (i = 0; i < 8 && q.size() != 0; i++) @(posedge clk);
      if (q.size() != 0) begin
         n_errors++;
         $display("[ERR] %0t read answer missing", $time);
         test_done();
      end
      @(posedge clk);
      `CHK(cfg, {sh[0][2:0], sh[1], sh[3], sh[2], sh[5], sh[4], sh[6], sh[8][7:6], sh[7],
         sh[8][5:0]})
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // two passes: reset values, then random back-to-back traffic, then a mid-run reset
   initial begin
      int i, k;
      logic [31:0] r;
      sh = rv;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      for (k = 0; k < 2; k++) begin
         for (i = 0; i < 9; i++) op(1'b0, 1'b1, 8'h10 + 8'(i), 8'h00);
         drain();
         for (i = 0; i < 80; i++) begin
            r = $random(seed);
            op(r[16], r[17], 8'h0E + 8'(r[7:0] % 12), r[15:8]);
         end
         drain();
         reset <= 1'b1;
         sh = rv;
         @(posedge clk);
         reset <= 1'b0;
      end
      test_done();
   end
endmodule
`default_nettype wire
